// *** rtl/xip_pkg.sv ***
// Operation
// RULE_01: Command low half keeps legacy layout, no status
// RULE_02: Command destination field is 32 bits wide
// RULE_03: One command write dispatches the interrupt
// RULE_04: Command readback is for debug only
// RULE_05: All-ones destination broadcasts in both modes
// RULE_06: Logical destination 32-bit, read-only, index 80DH
// RULE_07: Cluster in bits 31:16, logical 15:0
// RULE_08: Only clustered logical mode; no format register
// RULE_09: Unimplemented logical destination bits read zero
// RULE_10: Logical destination loaded on entering extended mode
// RULE_11: Cluster is id[19:4], logical is 1<<id[3:0]
// RULE_12: Sender ORs logical values within one cluster
// RULE_13: Topology leaf EDX gives full 32-bit id
// RULE_14: Initial id equals topology EDX bits 7:0
// RULE_15: Physical id register equals topology EDX
// RULE_16: Basic ECX bit 21 reports extended support
// RULE_17: Software checks leaf presence before use
// RULE_18: Software enables remapping before extended mode
// RULE_19: Firmware picks hand-over mode by id range
// RULE_20: Physical mode accepts own id or broadcast
package xip_pkg;
   localparam logic [11:0] XIP_IDX_PHYS_ID  = 12'h802;
   localparam logic [11:0] XIP_IDX_LOGICAL  = 12'h80D;
   localparam logic [11:0] XIP_IDX_DEST_FMT = 12'h80E;
   localparam logic [11:0] XIP_IDX_COMMAND  = 12'h830;
   localparam logic [31:0] XIP_BROADCAST    = 32'hFFFF_FFFF;
   localparam int          XIP_DS_BIT       = 12;
   localparam int          XIP_DEST_LSB     = 32;
   localparam int          XIP_CLUSTER_LSB  = 16;
   localparam int          XIP_ID_CL_LSB    = 4;
   localparam int          XIP_ID_CL_MSB    = 19;
   localparam logic [63:0] XIP_CMD_RESET    = 64'h0000_0000_0000_0000;
   localparam logic [31:0] XIP_ZERO32       = 32'h0000_0000;
   localparam logic [15:0] XIP_ONE16        = 16'h0001;

   function automatic logic [31:0] xip_derive_logical(input logic [31:0] id);
      xip_derive_logical = {id[XIP_ID_CL_MSB:XIP_ID_CL_LSB],
                            16'(XIP_ONE16 << id[XIP_ID_CL_LSB-1:0])};
   endfunction : xip_derive_logical

   function automatic logic [31:0] xip_field_mask(input int cl_bits, input int lg_bits);
      logic [15:0] cl;
      logic [15:0] lg;
      cl = 16'((17'h1_0000 >> (16 - cl_bits)) - 17'h0_0001);
      lg = 16'((17'h1_0000 >> (16 - lg_bits)) - 17'h0_0001);
      xip_field_mask = {cl, lg};
   endfunction : xip_field_mask
endpackage : xip_pkg

// *** rtl/xip_match_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface xip_match_if;
   logic [31:0] dest;
   logic        logical_mode;
   logic [31:0] own_phys;
   logic [31:0] own_logical;
   logic        hit;
   modport req (output dest, output logical_mode, output own_phys, output own_logical,
                input hit);
   modport mat (input dest, input logical_mode, input own_phys, input own_logical,
                output hit);
endinterface : xip_match_if
`default_nettype wire

// *** rtl/xip_dest_match.sv ***
`timescale 1ns/1ps
`default_nettype none
module xip_dest_match
   import xip_pkg::*;
(
   xip_match_if.mat m
);
   wire logic bcast_w;
   wire logic phys_hit_w;
   wire logic clus_hit_w;

   assign bcast_w    = (m.dest == XIP_BROADCAST);                    // RULE_05
   assign phys_hit_w = (m.dest == m.own_phys);                       // RULE_20
   // Clustered only: cluster equal and any shared logical bit
   assign clus_hit_w = (m.dest[31:XIP_CLUSTER_LSB] == m.own_logical[31:XIP_CLUSTER_LSB]) &&
                       ((m.dest[XIP_CLUSTER_LSB-1:0] &
                         m.own_logical[XIP_CLUSTER_LSB-1:0]) != 16'h0000); // RULE_08
   assign m.hit      = bcast_w || (m.logical_mode ? clus_hit_w : phys_hit_w);
endmodule : xip_dest_match
`default_nettype wire

// *** rtl/xip_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module xip_top
   import xip_pkg::*;
#(
   parameter int CLUSTER_BITS = 16,
   parameter int LOGICAL_BITS = 16,
   parameter bit EXT_SUPPORT  = 1'b1
)(
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic [31:0] physical_id_in,
   input  wire logic        ext_mode_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [11:0] reg_index_in,
   input  wire logic [63:0] reg_wdata_in,
   input  wire logic        msg_valid_in,
   input  wire logic [31:0] msg_dest_in,
   input  wire logic        msg_logical_in,
   output logic      [63:0] reg_rdata_out,
   output logic             reg_ack_out,
   output logic             reg_fault_out,
   output logic             ipi_valid_out,
   output logic      [31:0] ipi_cmd_out,
   output logic      [31:0] ipi_dest_out,
   output logic             ipi_broadcast_out,
   output logic             msg_accept_out,
   output logic      [31:0] topo_edx_out,
   output logic      [7:0]  initial_id_out,
   output logic             ext_support_out
);
   if (CLUSTER_BITS < 1 || CLUSTER_BITS > 16 ||
       LOGICAL_BITS < 1 || LOGICAL_BITS > 16) begin : g_chk
      $error("xip_top: field widths must be 1..16");
   end

   localparam logic [31:0] LOG_MASK = xip_field_mask(CLUSTER_BITS, LOGICAL_BITS);

   logic [31:0] phys_id_r;
   logic        id_taken_r;
   logic        ext_r;
   logic [31:0] logical_r;
   logic [63:0] cmd_r;
   logic [63:0] rdata_r;
   logic        ack_r;
   logic        fault_r;
   logic        ipi_valid_r;
   logic [31:0] ipi_cmd_r;
   logic [31:0] ipi_dest_r;
   logic        ipi_bcast_r;
   logic        accept_r;
   logic        ext_sup_r;

   xip_match_if mif ();

   xip_dest_match u_match (
      .m (mif.mat)
   );

   assign mif.dest         = msg_dest_in;
   assign mif.logical_mode = msg_logical_in;
   assign mif.own_phys     = phys_id_r;
   assign mif.own_logical  = logical_r;

   wire logic        enter_ext_w = ext_mode_in && !ext_r;
   wire logic        sel_phys_w  = (reg_index_in == XIP_IDX_PHYS_ID);
   wire logic        sel_log_w   = (reg_index_in == XIP_IDX_LOGICAL);
   wire logic        sel_cmd_w   = (reg_index_in == XIP_IDX_COMMAND);
   wire logic        access_w    = reg_wr_in || reg_rd_in;
   // Read-only targets, unmapped indexes (format register among them) and legacy mode fault
   wire logic        bad_w       = !ext_r || !(sel_phys_w || sel_log_w || sel_cmd_w) ||
                                   (reg_wr_in && !sel_cmd_w);               // RULE_06 RULE_08
   wire logic        cmd_wr_w    = reg_wr_in && !bad_w;
   wire logic [63:0] cmd_wval_w  = reg_wdata_in & ~(64'h1 << XIP_DS_BIT);  // RULE_01
   wire logic [63:0] rd_val_w    = sel_phys_w ? {XIP_ZERO32, phys_id_r} :  // RULE_15
                                   sel_log_w  ? {XIP_ZERO32, logical_r} :  // RULE_06
                                   cmd_r;                                   // RULE_04
   wire logic [31:0] load_w      = xip_derive_logical(phys_id_r) & LOG_MASK; // RULE_11 RULE_09

   // Identifier is caught once, after reset release
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         phys_id_r  <= XIP_ZERO32;
         id_taken_r <= 1'b0;
      end else if (!id_taken_r) begin
         phys_id_r  <= physical_id_in;
         id_taken_r <= 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ext_r     <= 1'b0;
         logical_r <= XIP_ZERO32;
      end else begin
         ext_r <= ext_mode_in;
         if (enter_ext_w) begin
            logical_r <= load_w;                                            // RULE_10 RULE_07
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cmd_r <= XIP_CMD_RESET;
      end else if (enter_ext_w) begin
         cmd_r <= {XIP_ZERO32, cmd_r[31:0]};
      end else if (cmd_wr_w) begin
         cmd_r <= cmd_wval_w;                                               // RULE_02
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rdata_r <= XIP_CMD_RESET;
         ack_r   <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         ack_r   <= access_w;
         fault_r <= access_w && bad_w;
         if (reg_rd_in && !bad_w) begin
            rdata_r <= rd_val_w;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ipi_valid_r <= 1'b0;
         ipi_cmd_r   <= XIP_ZERO32;
         ipi_dest_r  <= XIP_ZERO32;
         ipi_bcast_r <= 1'b0;
      end else begin
         ipi_valid_r <= cmd_wr_w;                                           // RULE_03
         if (cmd_wr_w) begin
            ipi_cmd_r   <= cmd_wval_w[31:0];
            ipi_dest_r  <= cmd_wval_w[63:XIP_DEST_LSB];
            ipi_bcast_r <= (cmd_wval_w[63:XIP_DEST_LSB] == XIP_BROADCAST);  // RULE_05
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         accept_r <= 1'b0;
      end else begin
         accept_r <= msg_valid_in && ext_r && mif.hit;                      // RULE_20
      end
   end

   // Capability flag sits in a flop so every output leaves a register
   always_ff @(posedge clock_in) begin
      ext_sup_r <= EXT_SUPPORT;                                             // RULE_16
   end

   assign reg_rdata_out     = rdata_r;
   assign reg_ack_out       = ack_r;
   assign reg_fault_out     = fault_r;
   assign ipi_valid_out     = ipi_valid_r;
   assign ipi_cmd_out       = ipi_cmd_r;
   assign ipi_dest_out      = ipi_dest_r;
   assign ipi_broadcast_out = ipi_bcast_r;
   assign msg_accept_out    = accept_r;
   assign topo_edx_out      = phys_id_r;                                    // RULE_13
   assign initial_id_out    = phys_id_r[7:0];                               // RULE_14
   assign ext_support_out   = ext_sup_r;                                    // RULE_16

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_cmd_write;
      reg_wr_in && ext_r && sel_cmd_w;
   endsequence
   sequence s_enter;
      ext_mode_in && !ext_r;
   endsequence

   cmd_no_status_a: assert property (s_cmd_write |=> !ipi_cmd_out[XIP_DS_BIT]) // RULE_01
      else $error("status bit leaked into command");
   cmd_dest_wide_a: assert property (s_cmd_write |=> // RULE_02
      ipi_dest_out == $past(reg_wdata_in[63:32]))
      else $error("destination not taken in full");
   // Back-to-back writes are legal, so each write is checked for its own pulse only
   single_write_a: assert property (s_cmd_write |=> ipi_valid_out) // RULE_03
      else $error("one write did not give one dispatch");
   no_stray_ipi_a: assert property (!(reg_wr_in && ext_r && sel_cmd_w) |=> // RULE_03
      !ipi_valid_out)
      else $error("dispatch without a command write");
   legacy_refuse_a: assert property ((reg_wr_in || reg_rd_in) && !ext_r |=> // RULE_03
      reg_fault_out && !ipi_valid_out)
      else $error("access served in legacy mode");
   bcast_flag_a: assert property (ipi_valid_out |-> // RULE_05
      ipi_broadcast_out == (ipi_dest_out == XIP_BROADCAST))
      else $error("broadcast flag wrong");
   bcast_accept_a: assert property ( // RULE_05
      msg_valid_in && ext_r && msg_dest_in == XIP_BROADCAST |=> msg_accept_out)
      else $error("broadcast message refused");
   ldr_ro_a: assert property (reg_wr_in && ext_r && sel_log_w |=> // RULE_06
      reg_fault_out && $stable(logical_r))
      else $error("logical destination written");
   ldr_read_a: assert property (reg_rd_in && ext_r && sel_log_w |=> // RULE_06
      !reg_fault_out && reg_rdata_out == {XIP_ZERO32, $past(logical_r)})
      else $error("logical destination read wrong");
   ldr_load_a: assert property (s_enter |=> // RULE_10
      logical_r == (xip_derive_logical($past(phys_id_r)) & LOG_MASK))
      else $error("logical destination not loaded");
   ldr_unimpl_a: assert property ((logical_r & ~LOG_MASK) == XIP_ZERO32) // RULE_09
      else $error("unimplemented bit set");
   fmt_absent_a: assert property (reg_rd_in && reg_index_in == XIP_IDX_DEST_FMT |=> // RULE_08
      reg_fault_out)
      else $error("format register answered");
   id_match_a: assert property (topo_edx_out[7:0] == initial_id_out) // RULE_14
      else $error("initial id mismatch");
   id_kept_a: assert property (id_taken_r |=> $stable(phys_id_r)) // RULE_15
      else $error("physical identifier changed");
   phys_read_a: assert property (reg_rd_in && ext_r && sel_phys_w |=> // RULE_15
      !reg_fault_out && reg_rdata_out == {XIP_ZERO32, topo_edx_out})
      else $error("physical identifier read differs");
   legacy_deaf_a: assert property (msg_valid_in && !ext_r |=> !msg_accept_out) // RULE_20
      else $error("message accepted in legacy mode");
   phys_accept_a: assert property (msg_valid_in && ext_r && !msg_logical_in &&
                                   msg_dest_in != phys_id_r && msg_dest_in != XIP_BROADCAST
                                   |=> !msg_accept_out) // RULE_20
      else $error("foreign physical message accepted");
endmodule : xip_top
`default_nettype wire

// *** dv/xip_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module xip_peer (
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic [31:0] dest_in,
   input  wire logic        logical_in,
   output logic             valid_out,
   output logic      [31:0] dest_out,
   output logic             logical_out
);
   initial begin
      valid_out = 1'b0;
      dest_out = 32'h0000_0000;
      logical_out = 1'b0;
   end
   // Idle lines show inverted last value so a stale match cannot pass
   // Request is taken at the edge and shown just after it, away from the design's edge
   always @(posedge clk_in) begin
      valid_out <= #1 go_in;
      dest_out <= #1 (go_in ? dest_in : ~dest_out);
      logical_out <= #1 (go_in ? logical_in : ~logical_out);
   end
endmodule : xip_peer
`default_nettype wire

// *** dv/tb_extended_mode_ipi_addressing.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_extended_mode_ipi_addressing
   import xip_pkg::*;
;
   logic clk = 0, rst_n = 0, ext = 0, wr = 0, rd = 0, go = 0, glog = 0, mv, ml;
   logic [11:0] idx = 0;
   logic [63:0] wd = 0, d;
   logic [31:0] id = 0, gd = 0, md, logical_destination, oth;
   logic [65:0] r;
   logic [65:0] rq[$];
   logic [64:0] iq[$];
   wire logic [63:0] rdat;
   wire logic        ack, flt, iv, bc, hit, es;
   wire logic [31:0] ic, idst, edx;
   wire logic [7:0]  iid;
   int fails = 0, compares = 0, aq = 0;
   always #12.5 clk = ~clk;
   xip_peer peer (.clk_in(clk), .go_in(go), .dest_in(gd), .logical_in(glog),
      .valid_out(mv), .dest_out(md), .logical_out(ml));
   xip_top #(.CLUSTER_BITS(12), .LOGICAL_BITS(8)) dut (.clock_in(clk), .rst_n_in(rst_n),
      .physical_id_in(id), .ext_mode_in(ext), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_index_in(idx), .reg_wdata_in(wd), .msg_valid_in(mv), .msg_dest_in(md),
      .msg_logical_in(ml), .reg_rdata_out(rdat), .reg_ack_out(ack), .reg_fault_out(flt),
      .ipi_valid_out(iv), .ipi_cmd_out(ic), .ipi_dest_out(idst), .ipi_broadcast_out(bc),
      .msg_accept_out(hit), .topo_edx_out(edx), .initial_id_out(iid),
      .ext_support_out(es));
   task summarize;
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task cmp(input logic [64:0] g, input logic [64:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task step;
      @(posedge clk);
      #1;
   endtask : step
   task acc(input logic w, input logic [11:0] i, input logic [63:0] v, input logic f,
            input logic [63:0] e);
      step;
      wr = w;
      rd = !w;
      idx = i;
      wd = v;
      go = 0;
      rq.push_back({!w, f, e});
      if (w && i == XIP_IDX_COMMAND && !f)
         iq.push_back({v[31:0] & ~32'h0000_1000, v[63:32], v[63:32] == XIP_BROADCAST});
   endtask : acc
   task msg(input logic [31:0] v, input logic l, input logic a);
      step;
      wr = 0;
      rd = 0;
      go = 1;
      gd = v;
      glog = l;
      aq += a;
   endtask : msg
   task idle;
      step;
      wr = 0;
      rd = 0;
      go = 0;
   endtask : idle
   // Acks and dispatches are matched in order against the notes left by the drivers, accepts against a count
   always @(posedge clk) begin
      #2;
      if (ack) begin
         if (rq.size() == 0) cmp(65'(1), 65'(0));
         else begin
            r = rq.pop_front();
            cmp({flt, (r[65] && !r[64]) ? rdat : r[63:0]}, r[64:0]);
         end
      end
      if (iv) begin
         if (iq.size() == 0) cmp(65'(1), 65'(0));
         else cmp({ic, idst, bc}, iq.pop_front());
      end
      if (hit) begin
         cmp(65'(aq > 0), 65'(1));
         aq--;
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      summarize;
   end
   initial begin
      void'($urandom(32'h821969c6));
      // Identifier kept above 255 so the hand-over lands in extended mode
      id = ($urandom & 32'h000F_FFF7) | 32'h0000_0100;
      logical_destination = {id[19:4], 16'h0001 << id[3:0]} & 32'h0FFF_00FF;
      oth = {logical_destination[31:16], 16'h0001 << ((id[2:0] + 3'h1) & 3'h7)};
      repeat (16) step;
      rst_n = 1;
      repeat (2) step;
      acc(0, XIP_IDX_PHYS_ID, 0, 1, 0);
      msg(id, 0, 0);
      repeat (3) idle;
      ext = 1;
      repeat (3) step;
      cmp(65'(edx), 65'(id));
      cmp(65'(iid), 65'(id[7:0]));
      cmp(65'(es), 65'(1));
      acc(0, XIP_IDX_PHYS_ID, 0, 0, {32'h0, id});
      acc(0, XIP_IDX_LOGICAL, 0, 0, {32'h0, logical_destination});
      acc(1, XIP_IDX_LOGICAL, '1, 1, 0);
      acc(0, XIP_IDX_DEST_FMT, 0, 1, 0);
      for (int k = 0; k < 6; k++) begin
         d = {$urandom, $urandom};
         d[12] = k[0];
         if (k == 2) d[63:32] = XIP_BROADCAST;
         acc(1, XIP_IDX_COMMAND, d, 0, 0);
      end
      acc(0, XIP_IDX_COMMAND, 0, 0, d & ~64'h1000);
      msg(id, 0, 1);
      msg(id ^ 32'h0000_0100, 0, 0);
      msg(XIP_BROADCAST, 0, 1);
      msg(XIP_BROADCAST, 1, 1);
      msg(logical_destination | oth, 1, 1);
      msg(logical_destination ^ 32'h0001_0000, 1, 0);
      repeat (5) idle;
      cmp(65'(rq.size() + iq.size() + aq), 65'(0));
      summarize;
   end
endmodule : tb_extended_mode_ipi_addressing
`default_nettype wire
